// [hdl/ctl_action_defs.vh]
/*
 Constants for the control character action block: register offsets,
 action table field positions, reset values and encodings.
 Assumes inclusion by bare name from the design files.
*/
`ifndef CTL_ACTION_DEFS_VH
`define CTL_ACTION_DEFS_VH

// Register byte offsets
`define OFF_ACT_TABLE    12'h000
`define OFF_TABLE_INDEX  12'h004
`define OFF_DETECT       12'h008
`define OFF_CONTROL      12'h00c
`define OFF_STATUS       12'h010
`define OFF_COUNT        12'h014
`define OFF_ADDR         12'h018

// Action table fields
`define ACT_CHK_LO       4
`define ACT_CHK_HI       5
`define ACT_RESYNC       6
`define ACT_STOP         7
`define ACT_STRIP        8
`define ACT_DLE          9
`define ACT_DOUBLE       14
`define ACT_SINGLE       15

// Control register fields
`define CTL_GO           0
`define CTL_SEC          1
`define CTL_TRANSP       2
`define CTL_SIZE_LO      4
`define CTL_SIZE_HI      7
`define CTL_CHK16        8

// Status register fields
`define ST_DONE_PRI      0
`define ST_DONE_SEC      1
`define ST_RX_ACTIVE     2
`define ST_SYNC1         3
`define ST_SYNC2         4
`define ST_CHK_BUSY      5

// Reset values
`define RST_CONTROL      16'h0080
`define RST_COUNT        16'h0000
`define RST_ADDR         16'h0000

// Wide check length in bits (two 8-bit check characters)
`define CHK_BITS_WIDE    16

`endif

// [hdl/chk_char_counter.v]
/*
 Counts block check characters still to be tested or appended.
 Assumes one load pulse at the control character and one step per
 following character boundary.
*/
module chk_char_counter #(
    parameter CW = 3
) (
    input  wire          sys_clk_i,
    input  wire          reset_i,
    input  wire          load_i,
    input  wire [1:0]    sel_i,
    input  wire          wide_i,
    input  wire [3:0]    size_i,
    input  wire          step_i,
    output reg           busy_o,
    output reg  [CW-1:0] left_o
);
    // Characters per check: sel 10 three, 01 two, 11 one
    function [CW-1:0] base_count;
        input [1:0] sel;
        begin
            case (sel)
                2'b10: base_count = 3'h3;
                2'b01: base_count = 3'h2;
                2'b11: base_count = 3'h1;
                default: base_count = 3'h0;
            endcase
        end
    endfunction

    wire [CW-1:0] base = base_count(sel_i);
    // A 16-bit check with short characters needs one per byte
    wire [CW-1:0] need = (wide_i && size_i <= 4'h8 && base != 3'h0) ?
                         3'h2 : base;

    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            left_o <= 3'h0;
            busy_o <= 1'b0;
        end else if (load_i) begin
            left_o <= need;
            busy_o <= (need != 3'h0);
        end else if (step_i && left_o != 3'h0) begin
            left_o <= left_o - 3'h1;
            busy_o <= (left_o != 3'h1);
        end
    end
endmodule

// [hdl/ctl_char_action.v]
/*
 Control character action logic: per-character action table, receive
 strip, resync, stop-and-done, check character handling, DLE strip and
 stuffing. Registers reached over APB; word count and buffer
 address step once per stored character.
 Assumes char_valid pulses at each character boundary with the
 detector's match index; the transfer logic owns counts and addresses.
*/
// Chosen here: the address map and the APB interface to the registers.
// Contract
// - Each check character has the selected character length; 16-bit check, 8-bit chars: two.
// - Received check characters under test are not stored; word count unchanged.
// - Receive interrupts held off while check processing runs.
// - Resync clears receive active and sync flags, keeps go, count and address.
// - Resync character goes to memory before receive active clears; here store_o rises on the same edge that clears it.
// - Stop-and-done clears go, sets done of the count register in use.
// - Stop-and-done never switches the active count register.
// - Done interrupt waits while a check test or append runs.
// - Strip withholds matched characters from memory but still accumulates check.
// - Single-match strip acts on narrow characters equal to detect value.
// - Double-match strip acts on a matched pair or wide character.
// - With both selectors set, double-match governs.
// - Receive DLE action with single match strips the leading DLE.
// - After a stripped DLE, a following SYNC is stripped too.
// - After a stripped DLE, a following DLE passes as data.
// - Transmit transparent DLE action inserts an extra DLE.
// - Stripped or inserted DLEs are excluded from the check.
// - Action entry used is the one at the detect entry's index.
// - An empty action entry gives normal handling.
`include "ctl_action_defs.vh"
module ctl_char_action #(
    parameter ENTRIES = 16,
    parameter IW      = 4
) (
    input  wire          sys_clk_i,
    input  wire          reset_i,
    input  wire          psel_i,
    input  wire          penable_i,
    input  wire          pwrite_i,
    input  wire [11:0]   paddr_i,
    input  wire [31:0]   pwdata_i,
    output reg  [31:0]   prdata_o,
    output reg           pready_o,
    output reg           pslverr_o,
    input  wire          char_valid_i,
    input  wire          char_tx_i,
    input  wire [15:0]   char_i,
    input  wire          char_match_i,
    input  wire          char_pair_i,
    input  wire [IW-1:0] char_index_i,
    input  wire          char_is_sync_i,
    input  wire          framing_i,
    output reg           store_o,
    output reg  [15:0]   store_data_o,
    output reg           tx_send_o,
    output reg  [15:0]   tx_data_o,
    output reg           chk_accum_o,
    output reg           count_step_o,
    output reg           rx_irq_enable_o,
    output reg           done_irq_o,
    output reg           go_o,
    output reg           rx_active_o
);
    reg  [15:0]   control_char_action_table [0:ENTRIES-1];
    reg  [IW-1:0] table_index;
    reg  [15:0]   detect;
    reg  [15:0]   control;
    reg           done_pri;
    reg           done_sec;
    reg           sync1;
    reg           sync2;
    reg           dle_seen;
    reg           done_wait;
    reg  [15:0]   count;
    reg  [15:0]   buf_addr;
    reg           stuff_pend;
    reg  [31:0]   next_prdata;
    reg           next_slverr;
    wire          chk_busy;

    wire [15:0] act = control_char_action_table[char_index_i];
    wire        hit = char_valid_i && char_match_i && (act != 16'h0000);
    wire        narrow = control[`CTL_SIZE_HI:`CTL_SIZE_LO] <= 4'h8;
    wire        is_dle = (char_i[7:0] == detect[7:0]);
    wire        access = psel_i && penable_i;
    wire        wr = access && pwrite_i;
    wire        transp = control[`CTL_TRANSP];
    // Per-register write strobes
    wire        wr_table   = wr && (paddr_i == `OFF_ACT_TABLE);
    wire        wr_index   = wr && (paddr_i == `OFF_TABLE_INDEX);
    wire        wr_detect  = wr && (paddr_i == `OFF_DETECT);
    wire        wr_control = wr && (paddr_i == `OFF_CONTROL);
    wire        wr_status  = wr && (paddr_i == `OFF_STATUS);
    wire        wr_count   = wr && (paddr_i == `OFF_COUNT);
    wire        wr_addr    = wr && (paddr_i == `OFF_ADDR);

    // Strip qualification by selector
    function strip_sel;
        input [15:0] a;
        input        pair;
        input        nar;
        input        eq;
        begin
            if (a[`ACT_DOUBLE])
                strip_sel = pair || !nar;
            else if (a[`ACT_SINGLE])
                strip_sel = nar && eq;
            else
                strip_sel = 1'b0;
        end
    endfunction

    wire rx_char  = char_valid_i && !char_tx_i;
    wire chk_char = rx_char && chk_busy;
    wire strip_hit = hit && !char_tx_i && act[`ACT_STRIP] &&
                     strip_sel(act, char_pair_i, narrow, char_i[7:0] == detect[7:0]);
    wire dle_strip = hit && !char_tx_i && act[`ACT_DLE] && act[`ACT_SINGLE] &&
                     !dle_seen;
    wire after_dle_sync = rx_char && dle_seen && char_is_sync_i;
    wire dle_stuff = hit && char_tx_i && transp && act[`ACT_DLE] && is_dle;
    wire chk_load = hit && (act[`ACT_CHK_HI:`ACT_CHK_LO] != 2'b00);

    chk_char_counter #(
        .CW (3)
    ) u_chk (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .load_i    (chk_load),
        .sel_i     (act[`ACT_CHK_HI:`ACT_CHK_LO]),
        .wide_i    (control[`CTL_CHK16]),
        .size_i    (control[`CTL_SIZE_HI:`CTL_SIZE_LO]),
        .step_i    (char_valid_i && !chk_load),
        .busy_o    (chk_busy),
        .left_o    ()
    );

    // Table writes
    always @(posedge sys_clk_i) begin
        if (wr_table)
            control_char_action_table[table_index] <= pwdata_i[15:0];
    end

    // Index and detect registers
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            table_index <= {IW{1'b0}};
            detect      <= 16'h0000;
        end else begin
            if (wr_index)
                table_index <= pwdata_i[IW-1:0];
            if (wr_detect)
                detect <= pwdata_i[15:0];
        end
    end

    // Word count and buffer address; a stored word outranks a write
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count    <= `RST_COUNT;
            buf_addr <= `RST_ADDR;
        end else begin
            if (wr_count)
                count <= pwdata_i[15:0];
            if (wr_addr)
                buf_addr <= pwdata_i[15:0];
            if (count_step_o) begin
                count    <= count - 16'h0001;
                buf_addr <= buf_addr + 16'h0001;
            end
        end
    end

    // Control register and go bit
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            control <= `RST_CONTROL;
            go_o    <= 1'b0;
        end else begin
            if (wr_control) begin
                control <= pwdata_i[15:0];
                go_o    <= pwdata_i[`CTL_GO];
            end
            if (hit && act[`ACT_STOP])
                go_o <= 1'b0;
        end
    end

    // Done flags, cleared by writing ones
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            done_pri <= 1'b0;
            done_sec <= 1'b0;
        end else begin
            if (wr_status) begin
                done_pri <= done_pri & ~pwdata_i[`ST_DONE_PRI];
                done_sec <= done_sec & ~pwdata_i[`ST_DONE_SEC];
            end
            // Set wins over a clear in the same cycle
            if (hit && act[`ACT_STOP]) begin
                if (control[`CTL_SEC])
                    done_sec <= 1'b1;
                else
                    done_pri <= 1'b1;
            end
        end
    end

    // Receive active and sync flags
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rx_active_o <= 1'b0;
            sync1       <= 1'b0;
            sync2       <= 1'b0;
        end else if (hit && act[`ACT_RESYNC] && !char_tx_i) begin
            // Resync wins over framing in the same cycle
            rx_active_o <= 1'b0;
            sync1       <= 1'b0;
            sync2       <= 1'b0;
        end else if (framing_i && go_o) begin
            rx_active_o <= 1'b1;
            sync1       <= 1'b1;
            sync2       <= 1'b1;
        end
    end

    // DLE memory and done interrupt
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dle_seen   <= 1'b0;
            done_wait  <= 1'b0;
            done_irq_o <= 1'b0;
        end else begin
            done_irq_o <= 1'b0;
            if (rx_char)
                dle_seen <= dle_strip;
            // Done pulse waits for the check counter to empty
            if (hit && act[`ACT_STOP]) begin
                done_wait <= 1'b1;
            end else if (done_wait && !chk_busy && !chk_load) begin
                done_wait  <= 1'b0;
                done_irq_o <= 1'b1;
            end
        end
    end

    // Datapath at the character boundary
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            store_o         <= 1'b0;
            store_data_o    <= 16'h0000;
            tx_send_o       <= 1'b0;
            tx_data_o       <= 16'h0000;
            chk_accum_o     <= 1'b0;
            count_step_o    <= 1'b0;
            rx_irq_enable_o <= 1'b1;
            stuff_pend      <= 1'b0;
        end else begin
            rx_irq_enable_o <= !(chk_busy || chk_load);
            // Resync char is stored in the same edge that drops active
            store_o      <= rx_char && !chk_char && !strip_hit &&
                            !dle_strip && !after_dle_sync;
            count_step_o <= rx_char && !chk_char && !strip_hit &&
                            !dle_strip && !after_dle_sync;
            store_data_o <= char_i;
            // A DLE passed as data stays in the check
            chk_accum_o  <= char_valid_i && !chk_char && !dle_strip &&
                            !after_dle_sync;
            // Extra DLE goes out the cycle after the data DLE
            tx_send_o    <= (char_valid_i && char_tx_i) || stuff_pend;
            stuff_pend   <= dle_stuff;
            if (!stuff_pend)
                tx_data_o <= char_i;
        end
    end

    // Read data for the register being addressed
    always @* begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (paddr_i)
            `OFF_ACT_TABLE:   next_prdata = {16'h0000, control_char_action_table[table_index]};
            `OFF_TABLE_INDEX: next_prdata = {{(32-IW){1'b0}}, table_index};
            `OFF_DETECT:      next_prdata = {16'h0000, detect};
            `OFF_CONTROL:     next_prdata = {16'h0000, control[15:1], go_o};
            `OFF_STATUS:      next_prdata = {26'h0000000, chk_busy, sync2, sync1,
                                             rx_active_o, done_sec, done_pri};
            `OFF_COUNT:       next_prdata = {16'h0000, count};
            `OFF_ADDR:        next_prdata = {16'h0000, buf_addr};
            default:          next_slverr = 1'b1;
        endcase
    end

    // APB slave, zero wait states
    // Decoded in the setup cycle, held through the access cycle
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && next_slverr;
            if (psel_i && !penable_i)
                prdata_o <= next_prdata;
        end
    end
endmodule

// [verif/ctl_char_action_asserts.sv]
/* Port checker for ctl_char_action: APB handshake and character actions.
   Assumes a bind to the top module; table and control shadowed from APB. */
`include "ctl_action_defs.vh"
module ctl_char_action_asserts #(
    parameter IW = 4
) (
    input logic          sys_clk_i,
    input logic          reset_i,
    input logic          psel_i,
    input logic          penable_i,
    input logic          pwrite_i,
    input logic [11:0]   paddr_i,
    input logic [31:0]   pwdata_i,
    input logic          pready_o,
    input logic          pslverr_o,
    input logic          char_valid_i,
    input logic          char_tx_i,
    input logic          char_match_i,
    input logic          char_pair_i,
    input logic [IW-1:0] char_index_i,
    input logic          store_o,
    input logic          tx_send_o,
    input logic          chk_accum_o,
    input logic          count_step_o,
    input logic          rx_irq_enable_o,
    input logic          done_irq_o,
    input logic          go_o,
    input logic          rx_active_o
);
    logic [15:0]   tbl [0:(1<<IW)-1];
    logic [IW-1:0] idx;
    logic [15:0]   ctl;
    wire           wr   = psel_i && penable_i && pwrite_i && pready_o;
    wire [15:0]    ent  = tbl[char_index_i];
    wire           hit  = char_valid_i && char_match_i;
    wire           live = go_o && rx_active_o && rx_irq_enable_o && !char_tx_i;
    // Shadow of software writes
    always @(posedge sys_clk_i) begin
        if (wr && paddr_i == `OFF_TABLE_INDEX) idx <= pwdata_i[IW-1:0];
        if (wr && paddr_i == `OFF_ACT_TABLE) tbl[idx] <= pwdata_i[15:0];
        if (wr && paddr_i == `OFF_CONTROL) ctl <= pwdata_i[15:0];
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    apb_ready_a: assert property (psel_i && penable_i |-> pready_o)
        else $error("no ready in access phase");
    ready_access_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    store_step_a: assert property (store_o |-> count_step_o)
        else $error("store without count step");
    check_unstored_a: assert property (char_valid_i && !char_tx_i && !rx_irq_enable_o
        |=> !store_o) else $error("check character stored");
    done_held_a: assert property (!rx_irq_enable_o |-> !done_irq_o)
        else $error("done during check");
    stop_go_a: assert property (hit && ent[`ACT_STOP] |=> !go_o)
        else $error("go kept after stop");
    resync_a: assert property (hit && !char_tx_i && go_o && ent == 16'h0040
        |=> store_o && go_o ##[0:1] !rx_active_o) else $error("resync wrong");
    strip_pair_a: assert property (hit && live && char_pair_i && ent == 16'hc100
        |=> !store_o && chk_accum_o) else $error("pair not stripped");
    plain_char_a: assert property (hit && live && ent == 16'h0000
        |=> store_o && chk_accum_o) else $error("plain char not handled");
    dle_insert_a: assert property (hit && char_tx_i && ctl[`CTL_TRANSP] && ent[`ACT_DLE]
        |-> ##[1:3] (tx_send_o && !chk_accum_o)) else $error("no extra DLE");
endmodule

// [verif/line_station_model.sv]
/* Remote station model: presents characters at boundaries, framing level.
   Assumes the bench calls send and frame just after a clock edge. */
module line_station_model (
    input  logic        sys_clk_i,
    output logic        char_valid_o,
    output logic        char_tx_o,
    output logic [15:0] char_o,
    output logic        char_match_o,
    output logic        char_pair_o,
    output logic [3:0]  char_index_o,
    output logic        char_is_sync_o,
    output logic        framing_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {char_valid_o, char_tx_o, char_o, char_match_o, char_pair_o} = '0;
        {char_index_o, char_is_sync_o, framing_o} = '0;
    end
    // One character, then char and index show the inverse while the strobes drop, then gap + 1 idle cycles
    task automatic send(input logic tx, input logic [15:0] ch, input logic m,
                        input logic pr, input logic [3:0] ix, input logic sy, input int gap);
        {char_valid_o, char_tx_o, char_o, char_match_o} <= {1'b1, tx, ch, m};
        {char_pair_o, char_index_o, char_is_sync_o} <= {pr, ix, sy};
        @(posedge sys_clk_i);
        {char_valid_o, char_match_o, char_pair_o, char_is_sync_o} <= '0;
        {char_o, char_index_o} <= ~{ch, ix};
        repeat (gap + 1) @(posedge sys_clk_i);
    endtask
    task automatic frame(input logic f);
        framing_o <= f;
        @(posedge sys_clk_i);
    endtask
endmodule

// [verif/control_char_action_logic_tb_top.sv]
/* Bench for ctl_char_action: APB registers and character actions.
   Assumes a 100 MHz clock and the station model as line partner. */
`include "ctl_action_defs.vh"
module control_char_action_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] DLE = 16'h0010;
    localparam logic [15:0] TAB [8] = '{16'h0000, 16'h0090, 16'h0040, 16'hc100,
                                        16'h8200, 16'h0030, 16'h8100, 16'h0000};
    logic        sys_clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, pready_o, pslverr_o, err;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rd;
    logic        char_valid_i, char_tx_i, char_match_i, char_pair_i, char_is_sync_i;
    logic        framing_i, store_o, tx_send_o, chk_accum_o, count_step_o;
    logic        rx_irq_enable_o, done_irq_o, go_o, rx_active_o;
    logic [15:0] char_i, store_data_o, tx_data_o, last_st;
    logic [3:0]  char_index_i;
    int          n_errors = 0, samples_checked = 0, n[4] = '{0, 0, 0, 0}, b[4];
    always #5 sys_clk_i = ~sys_clk_i;
    ctl_char_action dut_u (.*);
    line_station_model st_u (.sys_clk_i(sys_clk_i), .char_valid_o(char_valid_i),
        .char_tx_o(char_tx_i), .char_o(char_i), .char_match_o(char_match_i),
        .char_pair_o(char_pair_i), .char_index_o(char_index_i),
        .char_is_sync_o(char_is_sync_i), .framing_o(framing_i));
    // Event counts: store, check accumulate, transmit, done
    always @(posedge sys_clk_i) begin
        n[0] += int'(store_o === 1'b1);
        n[1] += int'(chk_accum_o === 1'b1);
        n[2] += int'(tx_send_o === 1'b1);
        n[3] += int'(done_irq_o === 1'b1);
        if (store_o === 1'b1) last_st <= store_data_o;
    end
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        @(posedge sys_clk_i);
        while (pready_o !== 1'b1 && k < 20) begin
            @(posedge sys_clk_i);
            k++;
        end
        {rd, err} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
        @(posedge sys_clk_i);
        if (k == 20) begin
            n_errors++;
            print_verdict();
        end
    endtask
    // Event deltas since last call, packed store/accum/tx/done
    task automatic delta(input logic [31:0] e, input logic [31:0] m);
        repeat (3) @(posedge sys_clk_i);
        chk({8'(n[0] - b[0]), 8'(n[1] - b[1]), 8'(n[2] - b[2]), 8'(n[3] - b[3])} & m, e);
        b = n;
    endtask
    initial begin
        b = n;
        repeat (6) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        apb(1'b0, `OFF_CONTROL, 0);
        chk(rd, {16'h0000, `RST_CONTROL});
        apb(1'b0, `OFF_COUNT, 0);
        chk(rd, {16'h0000, `RST_COUNT});
        apb(1'b0, 12'hffc, 0);
        chk(err, 1'b1);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `OFF_TABLE_INDEX, i);
            apb(1'b1, `OFF_ACT_TABLE, {16'h0000, i < 8 ? TAB[i & 7] : 16'h0000});
        end
        apb(1'b1, `OFF_TABLE_INDEX, 3);
        apb(1'b0, `OFF_ACT_TABLE, 0);
        chk(rd, 32'h0000c100);
        apb(1'b1, `OFF_DETECT, {16'h0000, DLE[7:0], DLE[7:0]});
        apb(1'b1, `OFF_CONTROL, 32'h0181);
        st_u.frame(1'b1);
        st_u.send(1'b0, 16'h0041, 1'b1, 1'b0, 4'h0, 1'b0, 0);
        delta(32'h01010000, '1);
        chk(last_st, 16'h0041);
        st_u.send(1'b0, 16'h0042, 1'b1, 1'b1, 4'h3, 1'b0, 2);
        delta(32'h00010000, '1);
        st_u.send(1'b0, 16'h0043, 1'b1, 1'b0, 4'h6, 1'b0, 0);
        delta(32'h01010000, '1);
        st_u.send(1'b0, DLE, 1'b1, 1'b0, 4'h6, 1'b0, 0);
        delta(32'h00010000, '1);
        st_u.send(1'b0, DLE, 1'b1, 1'b0, 4'h4, 1'b0, 0);
        st_u.send(1'b0, 16'h0016, 1'b0, 1'b0, 4'h0, 1'b1, 0);
        st_u.send(1'b0, DLE, 1'b1, 1'b0, 4'h4, 1'b0, 0);
        st_u.send(1'b0, DLE, 1'b1, 1'b0, 4'h4, 1'b0, 0);
        delta(32'h01010000, '1);
        chk(last_st, DLE);
        st_u.send(1'b0, 16'h0003, 1'b1, 1'b0, 4'h5, 1'b0, 0);
        chk(rx_irq_enable_o, 1'b0);
        st_u.send(1'b0, 16'h00aa, 1'b0, 1'b0, 4'h0, 1'b0, 0);
        st_u.send(1'b0, 16'h0055, 1'b0, 1'b0, 4'h0, 1'b0, 0);
        delta(32'h01000000, 32'hff00ffff);
        chk(rx_irq_enable_o, 1'b1);
        st_u.send(1'b0, 16'h0044, 1'b0, 1'b0, 4'h0, 1'b0, 0);
        delta(32'h01010000, '1);
        apb(1'b1, `OFF_CONTROL, 32'h0183);
        st_u.send(1'b0, 16'h0004, 1'b1, 1'b0, 4'h1, 1'b0, 0);
        delta(32'h01000000, 32'hff00ffff);
        chk(go_o, 1'b0);
        st_u.send(1'b0, 16'h00aa, 1'b0, 1'b0, 4'h0, 1'b0, 0);
        st_u.send(1'b0, 16'h0055, 1'b0, 1'b0, 4'h0, 1'b0, 0);
        delta(32'h00000001, 32'hff0000ff);
        apb(1'b0, `OFF_STATUS, 0);
        chk(rd[1:0], 2'b10);
        apb(1'b0, `OFF_CONTROL, 0);
        chk(rd, 32'h00000182);
        apb(1'b1, `OFF_CONTROL, 32'h0181);
        st_u.frame(1'b0);
        st_u.send(1'b0, 16'h0045, 1'b1, 1'b0, 4'h2, 1'b0, 0);
        chk({go_o, rx_active_o}, 2'b10);
        delta(32'h01000000, 32'hff00ffff);
        apb(1'b0, `OFF_STATUS, 0);
        chk(rd[4:2], 3'b000);
        st_u.frame(1'b1);
        apb(1'b0, `OFF_STATUS, 0);
        chk(rd[4:2], 3'b111);
        apb(1'b1, `OFF_CONTROL, 32'h0185);
        st_u.send(1'b1, DLE, 1'b1, 1'b0, 4'h4, 1'b0, 0);
        delta(32'h00010200, '1);
        print_verdict();
    end
endmodule
bind ctl_char_action ctl_char_action_asserts #(.IW(IW)) chk_u (.*);
